// *** verilog/aer_pkg.sv ***
// Purpose: Constants for the link-side error reporting register bank.
// Assumes: AHB-Lite register access, 32-bit words, byte addresses as printed.
// Notes: Shared by the register bank and its bench; the sticky storage does not import it.
package aer_pkg;
  localparam logic [11:0] AER_OFS_HEADER = 12'h100;
  localparam logic [11:0] AER_OFS_UNC_FLAGS = 12'h104;
  localparam logic [11:0] AER_OFS_UNC_MASK = 12'h108;
  localparam logic [11:0] AER_OFS_UNC_SEV = 12'h10c;
  localparam logic [11:0] AER_OFS_COR_FLAGS = 12'h110;
  localparam logic [11:0] AER_OFS_COR_MASK = 12'h114;
  localparam logic [11:0] AER_OFS_CAP_CTRL = 12'h118;
  localparam logic [11:0] AER_OFS_HDR0 = 12'h11c;
  localparam logic [11:0] AER_OFS_HDR1 = 12'h120;
  localparam logic [11:0] AER_OFS_HDR2 = 12'h124;
  localparam logic [11:0] AER_OFS_HDR3 = 12'h128;
  localparam logic [3:0] AER_VERSION = 4'h1;
  localparam logic [11:0] AER_NEXT_CAP = 12'h150;
  localparam int AER_VERSION_LSB = 16;
  localparam int AER_NEXT_LSB = 20;
  localparam logic [31:0] AER_UNC_VALID = 32'h001f_f011;
  localparam logic [31:0] AER_UNC_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] AER_UNC_SEV_RST = 32'h0006_2011;
  localparam logic [31:0] AER_COR_VALID = 32'h0000_31c1;
  localparam logic [31:0] AER_COR_MASK_RST = 32'h0000_2000;
  localparam int AER_ADV_NF_BIT = 13;
  localparam logic [31:0] AER_CTRL_RW = 32'h0000_0140;
  localparam int AER_FEP_LSB = 0;
  localparam int AER_FEP_W = 5;
  localparam int AER_GEN_CAP_BIT = 5;
  localparam int AER_GEN_EN_BIT = 6;
  localparam int AER_CHK_CAP_BIT = 7;
  localparam int AER_CHK_EN_BIT = 8;
  localparam int AER_HDR_WORDS = 4;
endpackage

// *** verilog/aer_sticky_reg.sv ***
// Purpose: One sticky register word cleared only by power-on reset.
// Assumes: Hardware set and software write arrive on the same clock.
// Notes: Set wins over a write-one clear in the same cycle.
`timescale 1ns/1ps
module aer_sticky_reg #(
  parameter int WIDTH = 32,
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
  parameter logic [31:0] VALID = 32'hffff_ffff,
  parameter bit W1C = 1'b0
) (
  input wire logic hclk,
  input wire logic porn,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] hw_set,
  output logic [WIDTH-1:0] q
);
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("aer_sticky_reg width out of range");
  end

  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    q_nxt = q;
    if (wr_en) begin
      q_nxt = W1C ? (q & ~wr_data) : wr_data;
    end
    q_nxt = (q_nxt | hw_set) & VALID[WIDTH-1:0];
  end

  always_ff @(posedge hclk or negedge porn) begin
    if (!porn) begin
      q <= RESET_VALUE[WIDTH-1:0];
    end else begin
      q <= q_nxt;
    end
  end
endmodule // aer_sticky_reg

// *** verilog/aer_regs.sv ***
// Purpose: Link-side advanced error reporting register bank on AHB-Lite.
// Assumes: Single clock hclk at 10 MHz; porn is power-on reset, hresetn ordinary reset.
// Notes: Error events arrive as one-cycle pulses from link logic on hclk.
// Function
// - Header word gives fixed next pointer 150h.
// - Uncorrectable flags sticky, write one clears.
// - Uncorrectable mask sticky read-write, reserved zero.
// - Severity sticky; bits 0,4,13,17,18 reset one.
// - Correctable flags sticky, write one clears.
// - Correctable mask sticky, resets zero except advisory.
// - Advisory non-fatal mask resets to one.
// - First error pointer sticky, read-only, resets zero.
// - CRC capable bits read one; enables sticky.
// - Four header words, byte zero in top.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module aer_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic porn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] unc_event,
  input wire logic [31:0] cor_event,
  input wire logic [127:0] event_header,
  output logic report_fatal,
  output logic report_nonfatal,
  output logic report_correctable,
  output logic crc_gen_enable,
  output logic crc_check_enable
);
  import aer_pkg::*;

  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] unc_flags;
  logic [31:0] unc_mask;
  logic [31:0] unc_sev;
  logic [31:0] cor_flags;
  logic [31:0] cor_mask;
  logic [31:0] ctrl_q;
  logic [127:0] hdr_q;
  logic [4:0] fep_r;
  logic [4:0] fep_nxt;
  logic [31:0] unc_new;
  logic [31:0] unc_rep;
  logic [31:0] cor_rep;
  logic hdr_cap;
  logic [31:0] rd_nxt;
  logic addr_ok;

  // Address phase capture; the bank never inserts wait states.
  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[11:0];
    end
  end

  function automatic logic wr_hit(input logic [11:0] ofs);
    wr_hit = wr_pend_r && (wr_addr_r == ofs);
  endfunction

  aer_sticky_reg #(.RESET_VALUE(32'h0000_0000), .VALID(AER_UNC_VALID), .W1C(1'b1)) u_unc_flags (
    .hclk(hclk), .porn(porn), .wr_en(wr_hit(AER_OFS_UNC_FLAGS)), .wr_data(hwdata),
    .hw_set(unc_event), .q(unc_flags));
  aer_sticky_reg #(.RESET_VALUE(AER_UNC_MASK_RST), .VALID(AER_UNC_VALID), .W1C(1'b0)) u_unc_mask (
    .hclk(hclk), .porn(porn), .wr_en(wr_hit(AER_OFS_UNC_MASK)), .wr_data(hwdata),
    .hw_set(32'h0000_0000), .q(unc_mask));
  aer_sticky_reg #(.RESET_VALUE(AER_UNC_SEV_RST), .VALID(AER_UNC_VALID), .W1C(1'b0)) u_unc_sev (
    .hclk(hclk), .porn(porn), .wr_en(wr_hit(AER_OFS_UNC_SEV)), .wr_data(hwdata),
    .hw_set(32'h0000_0000), .q(unc_sev));
  aer_sticky_reg #(.RESET_VALUE(32'h0000_0000), .VALID(AER_COR_VALID), .W1C(1'b1)) u_cor_flags (
    .hclk(hclk), .porn(porn), .wr_en(wr_hit(AER_OFS_COR_FLAGS)), .wr_data(hwdata),
    .hw_set(cor_event), .q(cor_flags));
  aer_sticky_reg #(.RESET_VALUE(AER_COR_MASK_RST), .VALID(AER_COR_VALID), .W1C(1'b0)) u_cor_mask (
    .hclk(hclk), .porn(porn), .wr_en(wr_hit(AER_OFS_COR_MASK)), .wr_data(hwdata),
    .hw_set(32'h0000_0000), .q(cor_mask));
  aer_sticky_reg #(.RESET_VALUE(32'h0000_0000), .VALID(AER_CTRL_RW), .W1C(1'b0)) u_ctrl (
    .hclk(hclk), .porn(porn), .wr_en(wr_hit(AER_OFS_CAP_CTRL)), .wr_data(hwdata),
    .hw_set(32'h0000_0000), .q(ctrl_q));

  assign crc_gen_enable = ctrl_q[AER_GEN_EN_BIT];
  assign crc_check_enable = ctrl_q[AER_CHK_EN_BIT];

  // Reporting is gated by the mask; the flags themselves are not.
  assign unc_rep = unc_event & AER_UNC_VALID & ~unc_mask;
  assign cor_rep = cor_event & AER_COR_VALID & ~cor_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      report_fatal <= 1'b0;
      report_nonfatal <= 1'b0;
      report_correctable <= 1'b0;
    end else begin
      report_fatal <= |(unc_rep & unc_sev);
      report_nonfatal <= |(unc_rep & ~unc_sev);
      report_correctable <= |cor_rep;
    end
  end

  // First error pointer and header capture happen when no unmasked flag is pending.
  assign unc_new = unc_event & AER_UNC_VALID & ~unc_mask;
  assign hdr_cap = (|unc_new) && ((unc_flags & ~unc_mask) == 32'h0000_0000);

  always_comb begin
    fep_nxt = fep_r;
    if (hdr_cap) begin
      for (int i = 31; i >= 0; i--) begin
        if (unc_new[i]) begin
          fep_nxt = 5'(i);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge porn) begin
    if (!porn) begin
      fep_r <= 5'h00;
    end else begin
      fep_r <= fep_nxt;
    end
  end

  always_ff @(posedge hclk or negedge porn) begin
    if (!porn) begin
      hdr_q <= 128'h0;
    end else if (hdr_cap) begin
      hdr_q <= event_header;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (haddr[11:0])
      AER_OFS_HEADER: rd_nxt = {AER_NEXT_CAP, AER_VERSION, 16'h0000};
      AER_OFS_UNC_FLAGS: rd_nxt = unc_flags;
      AER_OFS_UNC_MASK: rd_nxt = unc_mask;
      AER_OFS_UNC_SEV: rd_nxt = unc_sev;
      AER_OFS_COR_FLAGS: rd_nxt = cor_flags;
      AER_OFS_COR_MASK: rd_nxt = cor_mask;
      AER_OFS_CAP_CTRL: begin
        rd_nxt = ctrl_q;
        rd_nxt[AER_FEP_W-1:AER_FEP_LSB] = fep_r;
        rd_nxt[AER_GEN_CAP_BIT] = 1'b1;
        rd_nxt[AER_CHK_CAP_BIT] = 1'b1;
      end
      AER_OFS_HDR0: rd_nxt = hdr_q[127:96];
      AER_OFS_HDR1: rd_nxt = hdr_q[95:64];
      AER_OFS_HDR2: rd_nxt = hdr_q[63:32];
      AER_OFS_HDR3: rd_nxt = hdr_q[31:0];
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  chk_unc_w1c_clear: assert property (@(posedge hclk) disable iff (!porn || !hresetn)
    (wr_pend_r && wr_addr_r == AER_OFS_UNC_FLAGS && hwdata[0] && !unc_event[0]) |=> !unc_flags[0])
    else $error("uncorrectable flag not cleared");
  chk_unc_set_wins: assert property (@(posedge hclk) disable iff (!porn)
    unc_event[4] |=> unc_flags[4])
    else $error("uncorrectable flag not set");
  chk_unc_reserved_zero: assert property (@(posedge hclk) disable iff (!porn)
    (unc_flags & ~AER_UNC_VALID) == 32'h0 && (unc_mask & ~AER_UNC_VALID) == 32'h0)
    else $error("reserved uncorrectable bit set");
  chk_cor_set_flag: assert property (@(posedge hclk) disable iff (!porn)
    cor_event[13] |=> cor_flags[13])
    else $error("correctable flag not set");
  chk_cor_report_mask: assert property (@(posedge hclk) disable iff (!hresetn || !porn)
    (cor_event[0] && !cor_mask[0]) |=> report_correctable)
    else $error("correctable report missing");
  chk_fatal_sev: assert property (@(posedge hclk) disable iff (!hresetn || !porn)
    (unc_event[0] && !unc_mask[0] && unc_sev[0]) |=> report_fatal)
    else $error("fatal report missing");
  chk_fep_hold: assert property (@(posedge hclk) disable iff (!porn)
    !hdr_cap |=> $stable(fep_r))
    else $error("first error pointer moved");
  chk_crc_enable: assert property (@(posedge hclk) disable iff (!porn || !hresetn)
    (wr_pend_r && wr_addr_r == AER_OFS_CAP_CTRL) |=> crc_gen_enable == $past(hwdata[AER_GEN_EN_BIT]))
    else $error("crc enable not written");
  chk_hdr_hold: assert property (@(posedge hclk) disable iff (!porn)
    !hdr_cap |=> $stable(hdr_q))
    else $error("header log moved");
  chk_header_word: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[11:0] == AER_OFS_HEADER) |=> hrdata == 32'h1501_0000)
    else $error("capability header word wrong");
  chk_masked_silent: assert property (@(posedge hclk) disable iff (!hresetn || !porn)
    ((unc_event & AER_UNC_VALID & ~unc_mask) == 32'h0 && (cor_event & AER_COR_VALID & ~cor_mask) == 32'h0)
    |=> !(report_fatal || report_nonfatal || report_correctable))
    else $error("masked error reported");
  chk_sticky_keep: assert property (@(posedge hclk) disable iff (!porn)
    (!hresetn && unc_event == 32'h0 && cor_event == 32'h0) |=> ($stable(unc_flags) && $stable(cor_flags)))
    else $error("sticky flag lost in ordinary reset");
endmodule // aer_regs

// *** testbench/aer_regs_bench.sv ***
// Purpose: Self-checking bench for the link-side error reporting register bank.
// Assumes: AHB-Lite single word transfers; hready is fed back from hreadyout.
// Notes: Sticky state is checked across an ordinary reset and a power-on reset.
`timescale 1ns/1ps
module aer_regs_bench;
  import aer_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, porn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, unc_event = 32'h0, cor_event = 32'h0, hrdata, rdv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [127:0] event_header = 128'h0;
  logic hreadyout, hresp, report_fatal, report_nonfatal, report_correctable, crc_gen_enable, crc_check_enable;
  wire logic hready = hreadyout;
  int n_fail = 0, check_count = 0;
  logic [31:0] adr [12] = '{32'h100, 32'h104, 32'h108, 32'h10c, 32'h110, 32'h114, 32'h118,
    32'h11c, 32'h120, 32'h124, 32'h128, 32'h12c};
  logic [31:0] rst_v [12] = '{32'h1501_0000, 0, 0, 32'h0006_2011, 0, 32'h0000_2000, 32'h0000_00a0, 0, 0, 0, 0, 0};
  logic [31:0] one_v [12] = '{32'h1501_0000, 0, 32'h001f_f011, 32'h001f_f011, 0, 32'h0000_31c1, 32'h0000_01e0,
    0, 0, 0, 0, 0};
  localparam logic [127:0] HDR_A = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  localparam logic [127:0] HDR_B = 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f;
  always #50 hclk = ~hclk;
  aer_regs dut (.hclk(hclk), .hresetn(hresetn), .porn(porn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .unc_event(unc_event), .cor_event(cor_event), .event_header(event_header),
    .report_fatal(report_fatal), .report_nonfatal(report_nonfatal), .report_correctable(report_correctable),
    .crc_gen_enable(crc_gen_enable), .crc_check_enable(crc_check_enable));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic pulse(input logic [31:0] u, input logic [31:0] c, input logic [127:0] h, input logic [2:0] rep);
    @(posedge hclk);
    unc_event <= u; cor_event <= c; event_header <= h;
    @(posedge hclk);
    unc_event <= 32'h0; cor_event <= 32'h0;
    #1;
    chk({29'h0, report_fatal, report_nonfatal, report_correctable}, {29'h0, rep});
  endtask
  task automatic rst(input bit por);
    @(posedge hclk);
    hresetn <= 1'b0;
    if (por) porn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1; porn <= 1'b1;
  endtask
  task automatic hdr_chk(input logic [127:0] h);
    for (int i = 0; i < 4; i++) rc(32'h11c + 4 * i, h[127 - 32 * i -: 32]);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge hclk);
    n_fail++;
    close_out;
  end
  initial begin
    rst(1'b1);
    for (int i = 0; i < 12; i++) rc(adr[i], rst_v[i]);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) wr(adr[i], 32'hffff_ffff);
    for (int i = 0; i < 12; i++) rc(adr[i], one_v[i]);
    chk({30'h0, crc_gen_enable, crc_check_enable}, 32'h3);
    wr(32'h108, 32'h0); wr(32'h10c, 32'h0006_2011); wr(32'h114, 32'h0000_2000); wr(32'h118, 32'h0);
    chk({30'h0, crc_gen_enable, crc_check_enable}, 32'h0);
    $display("test write ones done");
    pulse(32'h0000_1000, 32'h0, HDR_A, 3'b010);
    rc(32'h104, 32'h0000_1000);
    rc(32'h118, 32'h0000_00ac);
    hdr_chk(HDR_A);
    pulse(32'h0000_0001, 32'h0, HDR_B, 3'b100);
    rc(32'h104, 32'h0000_1001);
    rc(32'h118, 32'h0000_00ac);
    hdr_chk(HDR_A);
    wr(32'h104, 32'h0);
    rc(32'h104, 32'h0000_1001);
    wr(32'h104, 32'h0000_1000);
    rc(32'h104, 32'h0000_0001);
    wr(32'h104, 32'h0000_0001);
    rc(32'h104, 32'h0);
    $display("test uncorrectable events done");
    wr(32'h108, 32'h0000_0010);
    pulse(32'h0000_0010, 32'h0, HDR_B, 3'b000);
    rc(32'h104, 32'h0000_0010);
    wr(32'h104, 32'h0000_0010); wr(32'h108, 32'h0);
    pulse(32'h0, 32'h0000_31c1, HDR_B, 3'b001);
    rc(32'h110, 32'h0000_31c1);
    wr(32'h110, 32'h0000_31c1);
    pulse(32'h0, 32'h0000_2000, HDR_B, 3'b000);
    rc(32'h110, 32'h0000_2000);
    wr(32'h110, 32'h0000_2000);
    rc(32'h110, 32'h0);
    $display("test mask and correctable done");
    pulse(32'h0000_4000, 32'h0, HDR_B, 3'b010);
    wr(32'h118, 32'h0000_0140);
    rst(1'b0);
    rc(32'h104, 32'h0000_4000);
    rc(32'h118, 32'h0000_01ee);
    hdr_chk(HDR_B);
    chk({30'h0, crc_gen_enable, crc_check_enable}, 32'h3);
    rst(1'b1);
    for (int i = 0; i < 12; i++) rc(adr[i], rst_v[i]);
    $display("test reset kinds done");
    close_out;
  end
endmodule // aer_regs_bench
